//--- ocpwm_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: unit runs only while control enable bit 15 is set
// R2: idle_stop bit 13 set halts the unit while the processor idles
// R3: wide_compare_select bit 5 picks 32-bit compare, else low 16 bits
// R4: pwm_fault_flag bit 4 is set by a fault, cleared only by hardware
// R5: pwm_fault_flag is used in mode 111 only, reads zero otherwise
// R6: timebase_select bit 3 picks timebase_b when set, timebase_a when clear
// R7: mode 111 is PWM honouring fault, 110 is PWM ignoring fault
// R8: mode 101 starts pin low, then repeating pulse train
// R9: mode 100 starts pin low, then exactly one pulse
// R10: mode 011 toggles the pin on every compare match
// R11: mode 010 starts pin high, match forces it low
// R12: mode 001 starts pin low, match forces it high
// R13: mode 000 disables compare; unit stays powered (code holds the pin low but primary matches still set IRQ_MATCH)
// R14: software skips register access in the cycle after clearing enable
// R15: unimplemented control bits 31:16, 14 and 12:6 read zero
// R16: match is count equal primary; pulse and PWM end on secondary
//////////////////////////////////////////////////////////////////////////////
package ocpwm_pkg;

  // register byte offsets
  localparam logic [11:0] ADDR_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_PRIMARY   = 12'h004;
  localparam logic [11:0] ADDR_SECONDARY = 12'h008;
  localparam logic [11:0] ADDR_INT_STAT  = 12'h00c;
  localparam logic [11:0] ADDR_INT_MASK  = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;

  // control field positions
  localparam int BIT_ENABLE    = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_WIDE      = 5;
  localparam int BIT_FAULT     = 4;
  localparam int BIT_TB_SEL    = 3;
  localparam int BIT_MODE_LO   = 0;

  // control writable bits, the flag bit is not among them
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_a02f;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;

  // interrupt status layout
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_PULSE = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W     = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // status register layout
  localparam int STAT_PIN    = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_DONE   = 2;

  // compare modes
  typedef enum logic [2:0] {
    MODE_OFF       = 3'h0,
    MODE_SET_HIGH  = 3'h1,
    MODE_SET_LOW   = 3'h2,
    MODE_TOGGLE    = 3'h3,
    MODE_SINGLE    = 3'h4,
    MODE_CONTINUE  = 3'h5,
    MODE_PWM       = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } ocpwm_mode_t;

endpackage

//--- ocpwm_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser, output moves when stages two and three agree
module ocpwm_sync (
  // clocking
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // pin and result
  input  wire logic pin_in,
  output logic      level_q
);

  logic meta_q;
  logic stage2_q;
  logic stage3_q;

  // chain, first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q   <= 1'b1;
      stage2_q <= 1'b1;
      stage3_q <= 1'b1;
    end else if (clk_en) begin
      meta_q   <= pin_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // accept a change once two stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= 1'b1;
    end else if (clk_en && (stage2_q == stage3_q)) begin
      level_q <= stage3_q;
    end
  end

endmodule

//--- ocpwm_unit.sv
`timescale 1ns/1ps
// output compare and pwm unit with apb register access
module ocpwm_unit (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timebases, same clock domain
  input  wire logic [31:0] timebase_a,
  input  wire logic [31:0] timebase_b,
  // system state and fault pin
  input  wire logic        cpu_idle,
  input  wire logic        fault_n,
  // outputs
  output logic             compare_output_pin,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] control_q;
  logic [31:0] primary_q;
  logic [31:0] secondary_q;
  logic [2:0]  int_stat_q;
  logic [2:0]  int_mask_q;
  logic        fault_flag_q;
  logic        pin_q;
  logic        done_q;
  logic        match_p_prev_q;
  logic        match_s_prev_q;
  logic [2:0]  mode_prev_q;
  logic        enable_prev_q;
  logic        fault_level;
  logic        fault_active;
  logic        enable;
  logic        running;
  logic        wide;
  ocpwm_pkg::ocpwm_mode_t mode;
  logic [31:0] count;
  logic        match_p;
  logic        match_s;
  logic        event_p;
  logic        event_s;
  logic        reinit;
  logic        pulse_end;
  logic        acc;
  logic        wr_en;
  logic [31:0] rd_data;
  logic        rd_hit;

  //////////////////////////////////////////////////////////////////////////
  // functions

  // offset decode, shared by read and write paths
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // compare at the selected width
  function automatic logic cmp_eq(input logic [31:0] c, input logic [31:0] v,
                                  input logic w);
    if (w) begin
      cmp_eq = (c == v);
    end else begin
      cmp_eq = (c[15:0] == v[15:0]);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // fault pin synchroniser
  ocpwm_sync u_fault_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .pin_in  (fault_n),
    .level_q (fault_level)
  );

  //////////////////////////////////////////////////////////////////////////
  // control decode
  assign enable  = control_q[ocpwm_pkg::BIT_ENABLE];
  assign mode    = ocpwm_pkg::ocpwm_mode_t'(control_q[ocpwm_pkg::BIT_MODE_LO +: 3]);
  assign wide    = control_q[ocpwm_pkg::BIT_WIDE];                    // see R3
  // halt while idling when asked to
  assign running = enable &&                                           // see R1
                   !(control_q[ocpwm_pkg::BIT_IDLE_STOP] && cpu_idle); // see R2

  // timebase selection
  assign count = control_q[ocpwm_pkg::BIT_TB_SEL] ? timebase_b      // see R6
                                                  : timebase_a;

  // compare matches, events on the first cycle of equality
  assign match_p = cmp_eq(count, primary_q, wide);                    // see R16
  assign match_s = cmp_eq(count, secondary_q, wide);                  // see R16
  assign event_p = running && match_p && !match_p_prev_q;
  assign event_s = running && match_s && !match_s_prev_q;

  // fault honoured only in fault pwm mode
  assign fault_active = (mode == ocpwm_pkg::MODE_PWM_FAULT) && !fault_level; // see R7

  // reinitialise pin on mode change or enable rising
  assign reinit = (control_q[2:0] != mode_prev_q) || (enable && !enable_prev_q);

  // pulse falling edge in pulse modes
  assign pulse_end = event_s && pin_q &&
                     ((mode == ocpwm_pkg::MODE_SINGLE) ||
                      (mode == ocpwm_pkg::MODE_CONTINUE));

  //////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait cycle, write lands when pready is seen
  assign acc   = psel && penable;
  assign wr_en = acc && pready && pwrite;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= acc && !pready;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (addr_is(paddr, ocpwm_pkg::ADDR_CONTROL)) begin
      // unimplemented bits stay zero, flag only in fault mode
      rd_data = control_q & ocpwm_pkg::CONTROL_WMASK;                 // see R15
      rd_data[ocpwm_pkg::BIT_FAULT] = fault_flag_q &&                  // see R5
                                      (mode == ocpwm_pkg::MODE_PWM_FAULT);
    end else if (addr_is(paddr, ocpwm_pkg::ADDR_PRIMARY)) begin
      rd_data = primary_q;
    end else if (addr_is(paddr, ocpwm_pkg::ADDR_SECONDARY)) begin
      rd_data = secondary_q;
    end else if (addr_is(paddr, ocpwm_pkg::ADDR_INT_STAT)) begin
      rd_data[2:0] = int_stat_q;
    end else if (addr_is(paddr, ocpwm_pkg::ADDR_INT_MASK)) begin
      rd_data[2:0] = int_mask_q;
    end else if (addr_is(paddr, ocpwm_pkg::ADDR_STATUS)) begin
      rd_data[ocpwm_pkg::STAT_PIN]    = pin_q;
      rd_data[ocpwm_pkg::STAT_ACTIVE] = running;
      rd_data[ocpwm_pkg::STAT_DONE]   = done_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read data and error captured with pready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (acc && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= !rd_hit;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register, flag bit not writable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_q <= ocpwm_pkg::CONTROL_RESET;
    end else if (clk_en && wr_en && addr_is(paddr, ocpwm_pkg::ADDR_CONTROL)) begin
      control_q <= pwdata & ocpwm_pkg::CONTROL_WMASK;                 // see R15
    end
  end

  // compare value registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      primary_q   <= ocpwm_pkg::COMPARE_RESET;
      secondary_q <= ocpwm_pkg::COMPARE_RESET;
    end else if (clk_en && wr_en) begin
      if (addr_is(paddr, ocpwm_pkg::ADDR_PRIMARY)) begin
        primary_q <= pwdata;
      end
      if (addr_is(paddr, ocpwm_pkg::ADDR_SECONDARY)) begin
        secondary_q <= pwdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // history for edge and mode-change detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_p_prev_q <= 1'b0;
      match_s_prev_q <= 1'b0;
      mode_prev_q    <= 3'h0;
      enable_prev_q  <= 1'b0;
    end else if (clk_en) begin
      if (running) begin
        match_p_prev_q <= match_p;
        match_s_prev_q <= match_s;
      end
      mode_prev_q   <= control_q[2:0];
      enable_prev_q <= enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fault flag, set by fault, cleared by hardware on fault-free period start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (fault_active && enable) begin
        fault_flag_q <= 1'b1;                                          // see R4
      end else if (mode != ocpwm_pkg::MODE_PWM_FAULT) begin
        fault_flag_q <= 1'b0;                                          // see R5
      end else if (event_p) begin
        fault_flag_q <= 1'b0;                                          // see R4
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // single pulse completion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (reinit || !enable) begin
        done_q <= 1'b0;
      end else if (pulse_end && (mode == ocpwm_pkg::MODE_SINGLE)) begin
        done_q <= 1'b1;                                                // see R9
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare output pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        pin_q <= 1'b0;                                                 // see R1
      end else if (reinit) begin
        // initial level per mode
        pin_q <= (mode == ocpwm_pkg::MODE_SET_LOW);                    // see R11
      end else if (running) begin
        unique case (mode)
          ocpwm_pkg::MODE_OFF: begin
            pin_q <= 1'b0;                                             // see R13
          end
          ocpwm_pkg::MODE_SET_HIGH: begin
            if (event_p) begin
              pin_q <= 1'b1;                                           // see R12
            end
          end
          ocpwm_pkg::MODE_SET_LOW: begin
            if (event_p) begin
              pin_q <= 1'b0;                                           // see R11
            end
          end
          ocpwm_pkg::MODE_TOGGLE: begin
            if (event_p) begin
              pin_q <= !pin_q;                                         // see R10
            end
          end
          ocpwm_pkg::MODE_SINGLE: begin
            if (event_p && !done_q) begin
              pin_q <= 1'b1;                                           // see R9
            end else if (event_s) begin
              pin_q <= 1'b0;                                           // see R16
            end
          end
          ocpwm_pkg::MODE_CONTINUE: begin
            if (event_p) begin
              pin_q <= 1'b1;                                           // see R8
            end else if (event_s) begin
              pin_q <= 1'b0;                                           // see R8
            end
          end
          ocpwm_pkg::MODE_PWM: begin
            if (event_p) begin
              pin_q <= 1'b1;                                           // see R7
            end else if (event_s) begin
              pin_q <= 1'b0;                                           // see R16
            end
          end
          ocpwm_pkg::MODE_PWM_FAULT: begin
            if (fault_active) begin
              pin_q <= 1'b0;                                           // see R7
            end else if (event_p) begin
              pin_q <= 1'b1;
            end else if (event_s) begin
              pin_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  assign compare_output_pin = pin_q;

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_stat_q <= ocpwm_pkg::IRQ_RESET;
    end else if (clk_en) begin
      for (int i = 0; i < ocpwm_pkg::IRQ_W; i++) begin
        if (wr_en && addr_is(paddr, ocpwm_pkg::ADDR_INT_STAT) && pwdata[i]) begin
          int_stat_q[i] <= 1'b0;
        end
      end
      if (event_p) begin
        int_stat_q[ocpwm_pkg::IRQ_MATCH] <= 1'b1;
      end
      if (pulse_end) begin
        int_stat_q[ocpwm_pkg::IRQ_PULSE] <= 1'b1;
      end
      if (fault_active && enable) begin
        int_stat_q[ocpwm_pkg::IRQ_FAULT] <= 1'b1;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_mask_q <= ocpwm_pkg::IRQ_RESET;
    end else if (clk_en && wr_en && addr_is(paddr, ocpwm_pkg::ADDR_INT_MASK)) begin
      int_mask_q <= pwdata[2:0];
    end
  end

  // registered interrupt level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(int_stat_q & int_mask_q);
    end
  end

endmodule

//--- ocpwm_properties.sv
`timescale 1ns/1ps
// port-level checks of bus timing, control read-back and pin behaviour
module ocpwm_properties (
  // clocking
  input wire logic        ref_clk,
  input wire logic        rst,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin
  input wire logic        compare_output_pin
);
  logic [31:0] ctl_q;
  logic        rd_ctl;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////
  // shadow of the writable control bits, taken where a write lands
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_q <= 32'h0;
    end else if (psel && penable && pready && pwrite && paddr == ocpwm_pkg::ADDR_CONTROL) begin
      ctl_q <= pwdata & ocpwm_pkg::CONTROL_WMASK;
    end
  end

  // control read response
  assign rd_ctl = pready && !pwrite && paddr == ocpwm_pkg::ADDR_CONTROL;

  //////////////////////////////////////////////////////////////////////////
  apb_one_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access start");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  apb_idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside a response");
  apb_err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  ctl_unimpl_a: assert property (rd_ctl |-> (prdata & ~32'h0000_a03f) == 32'h0)
    else $error("unimplemented control bit reads one");
  fault_zero_a: assert property (rd_ctl && prdata[2:0] != 3'h7 |-> !prdata[4])
    else $error("fault flag set outside fault pwm mode");
  off_low_a: assert property (!ctl_q[15] && !$past(ctl_q[15]) |-> !compare_output_pin)
    else $error("pin high while unit disabled");
  mode_off_a: assert property (ctl_q[2:0] == 3'h0 && $past(ctl_q[2:0]) == 3'h0
    |-> !compare_output_pin) else $error("pin high with compare off");
  set_high_hold_a: assert property (ctl_q[15] && ctl_q[2:0] == 3'h1 && $past(ctl_q[15], 2)
    && $past(ctl_q[2:0], 2) == 3'h1 |-> !$fell(compare_output_pin))
    else $error("pin fell in set high mode");
  set_low_hold_a: assert property (ctl_q[15] && ctl_q[2:0] == 3'h2 && $past(ctl_q[15], 2)
    && $past(ctl_q[2:0], 2) == 3'h2 |-> !$rose(compare_output_pin))
    else $error("pin rose in set low mode");
endmodule

bind ocpwm_unit ocpwm_properties ocpwm_properties_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_output_pin(compare_output_pin));

//--- ocpwm_load.sv
`timescale 1ns/1ps
// load on the compare pin: counts rising edges and times high pulses
module ocpwm_load (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // pin and count clear
  input  wire logic        pin,
  input  wire logic        clr,
  // observations
  output logic      [15:0] rises,
  output logic      [15:0] width
);
  logic        pin_q;
  logic [15:0] run_q;

  // edge and width bookkeeping
  always_ff @(posedge ref_clk) begin
    pin_q <= pin;
    run_q <= pin ? run_q + 16'h1 : 16'h0;
    if (rst || clr) begin
      rises <= 16'h0;
    end else if (pin && !pin_q) begin
      rises <= rises + 16'h1;
    end
    if (!pin && pin_q) begin
      width <= run_q; // high time of the last pulse
    end
  end
endmodule

//--- tb_output_compare_pwm_unit.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
    end \
  end

module tb_output_compare_pwm_unit;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tb_b, p_v, s_v, rd;
  logic        cpu_idle, fault_n, pin, irq, clr, err;
  logic [5:0]  a_q;
  logic [15:0] rises, width;
  int          miscompares, num_checks;

  ocpwm_unit ocpwm_unit_i (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_a({26'h0, a_q}), .timebase_b(tb_b), .cpu_idle(cpu_idle),
    .fault_n(fault_n), .compare_output_pin(pin), .irq(irq));
  ocpwm_load ocpwm_load_i (.ref_clk(ref_clk), .rst(rst), .pin(pin), .clr(clr),
    .rises(rises), .width(width));

  //////////////////////////////////////////////////////////////////////////
  // clock and a timebase wrapping every 64 cycles
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) a_q <= rst ? 6'h0 : a_q + 6'h1;

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk); // idle cycle after each transfer
    if (n >= 50) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    `CHK(nm, ex, d)
  endtask

  // write control at a fixed timebase phase, then watch four periods
  task automatic run(input logic [31:0] c, input logic idl);
    int n;
    n = 0;
    while (a_q !== 6'h28 && n < 70) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 70) begin
      miscompares++;
      close_out();
    end
    cpu_idle <= idl;
    wr(ocpwm_pkg::ADDR_CONTROL, c);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (255) @(posedge ref_clk);
    $display("test with control %h done", c);
  endtask

  // rising edges expected over four periods for each mode
  function automatic logic [15:0] exp_rises(input logic [2:0] m);
    case (m)
      3'h0, 3'h2: return 16'h0;
      3'h1, 3'h4: return 16'h1;
      3'h3: return 16'h2;
      default: return 16'h4;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {cpu_idle, fault_n, clr, miscompares, num_checks} = {1'b0, 1'b1, 1'b0, 64'h0};
    rd = $urandom(32'h52a9acfb);
    tb_b = $urandom() | 32'h0000_0100;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, access kinds and an unmapped address
    chk_rd(ocpwm_pkg::ADDR_CONTROL, 32'h0, "control reset");
    chk_rd(ocpwm_pkg::ADDR_INT_STAT, 32'h0, "int status reset");
    wr(ocpwm_pkg::ADDR_CONTROL, 32'hffff_ffff);
    chk_rd(ocpwm_pkg::ADDR_CONTROL, 32'h0000_a02f, "control bits");
    apb(1'b0, 12'h018, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // every compare mode with random compare values
    for (int m = 0; m < 8; m++) begin
      p_v = 32'h2 + $urandom_range(13);
      s_v = p_v + 32'h5 + $urandom_range(15);
      wr(ocpwm_pkg::ADDR_PRIMARY, p_v);
      wr(ocpwm_pkg::ADDR_SECONDARY, s_v);
      run(32'h0000_8000 | m, 1'b0);
      `CHK("mode rises", exp_rises(m[2:0]), rises)
      if (m >= 4) `CHK("pulse width", s_v[15:0] - p_v[15:0], width)
    end
    // interrupt raised, masked and cleared
    chk_rd(ocpwm_pkg::ADDR_INT_STAT, 32'h3, "event status");
    `CHK("irq masked", 1'b0, irq)
    wr(ocpwm_pkg::ADDR_INT_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK("irq raised", 1'b1, irq)
    wr(ocpwm_pkg::ADDR_CONTROL, 32'h0);
    wr(ocpwm_pkg::ADDR_INT_STAT, 32'h7);
    chk_rd(ocpwm_pkg::ADDR_INT_STAT, 32'h0, "status cleared");
    `CHK("irq cleared", 1'b0, irq)
    // toggle mode under enable, idle, timebase and width settings
    for (int i = 0; i < 7; i++) begin
      wr(ocpwm_pkg::ADDR_PRIMARY, p_v | (i >= 5 ? 32'h0001_0000 : 32'h0));
      run(i == 0 ? 32'h3 : (i < 3 ? 32'ha003 : (i == 4 ? 32'h800b : (i == 5 ? 32'h8023
          : 32'h8003))), i == 1 || i == 3);
      `CHK("gated rises", (i == 2 || i == 3 || i == 6) ? 16'h2 : 16'h0, rises)
    end
    // fault pin low: honoured in fault pwm, ignored in plain pwm
    wr(ocpwm_pkg::ADDR_PRIMARY, p_v);
    fault_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    run(32'h0000_8007, 1'b0);
    `CHK("fault rises", 16'h0, rises)
    chk_rd(ocpwm_pkg::ADDR_CONTROL, 32'h0000_8017, "fault flag");
    apb(1'b0, ocpwm_pkg::ADDR_INT_STAT, 32'h0, rd, err);
    `CHK("fault status", 1'b1, rd[2])
    run(32'h0000_8006, 1'b0);
    `CHK("fault ignored", 16'h4, rises)
    chk_rd(ocpwm_pkg::ADDR_CONTROL, 32'h0000_8006, "flag outside pwm");
    fault_n <= 1'b1;
    run(32'h0000_8017, 1'b0);
    chk_rd(ocpwm_pkg::ADDR_CONTROL, 32'h0000_8007, "flag write ignored");
    close_out();
  end
endmodule
